// ### ahp_adc_model.sv
`timescale 1ns/10ps
module ahp_adc_model (
  // host pins
  input wire logic        mode,
  input wire logic        cs_n,
  input wire logic        wr_n,
  input wire logic        rd_n,
  input wire logic        sleep_n,
  // input level as code, lower-nibble delay in ns
  input wire logic [7:0]  vin,
  input wire logic [11:0] dly,
  // answers
  output logic            int_n,
  output logic [7:0]      result_bus
);
  logic [7:0] smp;
  logic [7:0] lat = 8'h00;
  logic       busy = 1'b0;
  initial int_n = 1'b1;
  // falling convert strobe samples; stand-alone has no other flag reset
  // select and strobe leave one host register together, so select is read just after
  always @(negedge wr_n) begin
    #1;
    if (!cs_n && mode && sleep_n) begin
      smp = vin;
      busy = 1'b1;
      int_n = 1'b1;
    end
  end
  // rise latches upper nibble, lower one after the internal delay
  always @(posedge wr_n) if (busy) begin
    lat[7:4] = smp[7:4];
    #(dly) if (busy) begin
      lat[3:0] = smp[3:0];
      busy = 1'b0;
      int_n = 1'b0;
    end
  end
  // early read ends the conversion at once
  always @(negedge rd_n) if (busy && wr_n && !cs_n) begin
    lat = smp;
    busy = 1'b0;
    #100 int_n = 1'b0;
  end
  // first rise of select or read clears the flag
  always @(posedge cs_n or posedge rd_n) int_n = 1'b1;
  // a released bus shows the inverse, so stale data cannot pass
  assign result_bus = (!cs_n && !rd_n) ? lat : ~lat;
endmodule

// ### ahp_consts.svh
`ifndef AHP_CONSTS_SVH
`define AHP_CONSTS_SVH

// host clock period
`define AHP_CLK_NS        50
// converter pin timing, figures in ns
`define AHP_WR_LOW_NS     600
`define AHP_RD_WAIT_NS    800
`define AHP_ACC_NS        400
`define AHP_ACQ_NS        450
`define AHP_WAKE_NS       900
`define AHP_SWITCH_ON_NS  100
// least times, rounded up to whole cycles
`define AHP_CYC(ns)       (((ns) + `AHP_CLK_NS - 1) / `AHP_CLK_NS)
`define AHP_WR_LOW_CYC    `AHP_CYC(`AHP_WR_LOW_NS)
`define AHP_RD_WAIT_CYC   `AHP_CYC(`AHP_RD_WAIT_NS)
`define AHP_ACC_CYC       `AHP_CYC(`AHP_ACC_NS)
`define AHP_ACQ_CYC       `AHP_CYC(`AHP_ACQ_NS)
`define AHP_WAKE_CYC      `AHP_CYC(`AHP_WAKE_NS + `AHP_SWITCH_ON_NS)
// operating ways
`define AHP_OP_INTERNAL   2'h0
`define AHP_OP_EARLY      2'h1
`define AHP_OP_STANDALONE 2'h2
// widths
`define AHP_DATA_W        8
`define AHP_FIFO_DEPTH    16
`define AHP_CNT_W         8

`endif

// ### ahp_host.sv
`timescale 1ns/10ps
`include "ahp_consts.svh"

module ahp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clocking
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } ahp_fifo_t;

  ahp_fifo_t s;
  ahp_fifo_t next_s;
  logic      full;
  logic      empty;

  // extra pointer bit tells full from empty
  assign empty     = (s.wp == s.rp);
  assign full      = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = s.mem[s.rp[AW-1:0]];

  // pointer and storage update
  always_comb begin
    next_s = s;
    if (in_valid && !full) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp                = s.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

module ahp_host (
  // clock, reset, enable
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST,
  input  wire logic                   CE,
  // user command side
  input  wire logic                   START,
  input  wire logic [1:0]             OPMODE,
  input  wire logic                   SLEEP,
  output logic                        BUSY,
  // results toward the user
  output logic                        OUT_VALID,
  input  wire logic                   OUT_READY,
  output logic [`AHP_DATA_W-1:0]      OUT_DATA,
  // converter pins
  output logic                        MODE,
  output logic                        CS_N,
  output logic                        WR_N,
  output logic                        RD_N,
  output logic                        SLEEP_N,
  output logic                        VREF_ON,
  input  wire logic                   INT_N,
  input  wire logic [`AHP_DATA_W-1:0] RESULT_BUS
);
  ahp_pkg::ahp_regs_t s;
  ahp_pkg::ahp_regs_t next_s;
  logic               fifo_ready;

  // the result keeps the bus order, top line is the msb
  ahp_fifo #(
    .W     (`AHP_DATA_W),
    .DEPTH (`AHP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .ce        (CE),
    .in_valid  (s.push),
    .in_ready  (fifo_ready),
    .in_data   (s.data),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );

  // pin drive straight from the state flops, mode tied high
  assign MODE    = 1'b1;
  assign CS_N    = s.pins.cs_n;
  assign WR_N    = s.pins.wr_n;
  assign RD_N    = s.pins.rd_n;
  assign SLEEP_N = s.pins.sleep_n;
  assign VREF_ON = s.pins.vref_on;
  assign BUSY    = (s.state != ahp_pkg::ST_IDLE);

  // sequencer; fifo room is checked at start so no result drops on a full fifo
  always_comb begin
    next_s      = s;
    next_s.push = 1'b0;
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    unique case (s.state)
      ahp_pkg::ST_IDLE: begin
        // stand-alone keeps select and read tied low
        next_s.pins.cs_n = (OPMODE != `AHP_OP_STANDALONE);
        next_s.pins.rd_n = (OPMODE != `AHP_OP_STANDALONE);
        if (OPMODE != `AHP_OP_STANDALONE) begin
          next_s.have_prev = 1'b0;
        end
        if (SLEEP) begin
          next_s.pins      = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                               sleep_n: 1'b0, vref_on: 1'b0};
          next_s.have_prev = 1'b0;
          next_s.state     = ahp_pkg::ST_SLEEP;
        end else if (START && fifo_ready) begin
          next_s.op        = OPMODE;
          next_s.pins.cs_n = 1'b0;
          next_s.pins.wr_n = 1'b0;
          next_s.cnt       = `AHP_CNT_W'(`AHP_WR_LOW_CYC - 1);
          next_s.state     = ahp_pkg::ST_WRLO;
          // previous result taken on the falling edge of the next pulse
          if (OPMODE == `AHP_OP_STANDALONE && s.have_prev) begin
            next_s.push = 1'b1;
            next_s.data = RESULT_BUS;
          end
        end
      end
      ahp_pkg::ST_WRLO: begin
        if (s.cnt == '0) begin
          next_s.pins.wr_n = 1'b1;
          if (s.op == `AHP_OP_EARLY) begin
            next_s.cnt   = `AHP_CNT_W'(`AHP_RD_WAIT_CYC - 1);
            next_s.state = ahp_pkg::ST_GAP;
          end else begin
            next_s.state = ahp_pkg::ST_WINT;
          end
        end
      end
      ahp_pkg::ST_WINT: begin
        // no timeout: a silent converter holds the host here
        if (!INT_N) begin
          if (s.op == `AHP_OP_STANDALONE) begin
            next_s.have_prev = 1'b1;
            next_s.cnt       = `AHP_CNT_W'(`AHP_ACQ_CYC - 1);
            next_s.state     = ahp_pkg::ST_ACQ;
          end else begin
            next_s.pins.rd_n = 1'b0;
            next_s.cnt       = `AHP_CNT_W'(`AHP_ACC_CYC - 1);
            next_s.state     = ahp_pkg::ST_RDLO;
          end
        end
      end
      ahp_pkg::ST_GAP: begin
        if (s.cnt == '0) begin
          next_s.pins.rd_n = 1'b0;
          next_s.cnt       = `AHP_CNT_W'(`AHP_ACC_CYC - 1);
          next_s.state     = ahp_pkg::ST_RDLO;
        end
      end
      ahp_pkg::ST_RDLO: begin
        // sample at the end of access time, bus is still driven
        if (s.cnt == '0) begin
          next_s.push      = 1'b1;
          next_s.data      = RESULT_BUS;
          next_s.pins.rd_n = 1'b1;
          next_s.pins.cs_n = 1'b1;
          next_s.cnt       = `AHP_CNT_W'(`AHP_ACQ_CYC - 1);
          next_s.state     = ahp_pkg::ST_ACQ;
        end
      end
      ahp_pkg::ST_ACQ: begin
        // counted from the end of the read, or from the flag in stand-alone: conservative for tracking
        if (s.cnt == '0) begin
          next_s.state = ahp_pkg::ST_IDLE;
        end
      end
      ahp_pkg::ST_SLEEP: begin
        if (!SLEEP) begin
          next_s.pins.sleep_n = 1'b1;
          next_s.pins.vref_on = 1'b1;
          next_s.cnt          = `AHP_CNT_W'(`AHP_WAKE_CYC - 1);
          next_s.state        = ahp_pkg::ST_WAKE;
        end
      end
      ahp_pkg::ST_WAKE: begin
        if (s.cnt == '0) begin
          next_s.state = ahp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.state = ahp_pkg::ST_IDLE;
      end
    endcase
  end

  // all state frozen while the enable is low
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s       <= '0;
      s.state <= ahp_pkg::ST_IDLE;
      s.pins  <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, sleep_n: 1'b1, vref_on: 1'b1};
    end else if (CE) begin
      s <= next_s;
    end
  end
endmodule

// ### ahp_host_asserts.sv
`timescale 1ns/10ps
module ahp_host_asserts (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // converter pins
  input wire logic MODE,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic SLEEP_N,
  input wire logic VREF_ON,
  input wire logic INT_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // pin timing in 50 ns cycles
  mode_held_a: assert property (MODE)
    else $error("mode pin low");
  strobe_select_a: assert property ((!WR_N || !RD_N) |-> !CS_N)
    else $error("strobe without select");
  write_width_a: assert property ($fell(WR_N) |-> !WR_N[*8] ##1 !WR_N[*4] ##1 WR_N)
    else $error("convert pulse not 600 ns");
  read_width_a: assert property ($fell(RD_N) && !$fell(CS_N) |-> !RD_N[*8] ##1 (RD_N && CS_N))
    else $error("read pulse not 400 ns");
  acq_time_a: assert property ($fell(INT_N) |-> WR_N[*8] ##1 WR_N)
    else $error("acquisition cut short");
  wake_wait_a: assert property ($rose(SLEEP_N) |-> WR_N[*8] ##1 WR_N[*8] ##1 WR_N[*4])
    else $error("convert too soon after wake");
  sleep_quiet_a: assert property (!SLEEP_N |-> !VREF_ON && WR_N && RD_N && CS_N)
    else $error("pins active in sleep");
  convert_awake_a: assert property (!WR_N |-> SLEEP_N && VREF_ON)
    else $error("convert while asleep");
endmodule
bind ahp_host ahp_host_asserts ahp_host_asserts_i (.SYS_CLK(SYS_CLK), .RST(RST), .MODE(MODE),
  .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N), .SLEEP_N(SLEEP_N), .VREF_ON(VREF_ON), .INT_N(INT_N));

// ### ahp_host_test.sv
`timescale 1ns/10ps
module ahp_host_test;
  logic       SYS_CLK, RST, CE, START, SLEEP, OUT_READY, BUSY, OUT_VALID;
  logic       MODE, CS_N, WR_N, RD_N, SLEEP_N, VREF_ON, INT_N;
  logic [1:0] OPMODE;
  logic [7:0] OUT_DATA, RESULT_BUS, vin, v;
  logic [11:0] dly;
  int         fails, comparisons, seed, i;
  logic [7:0] q[$];

  ahp_host ahp_host_i (.SYS_CLK, .RST, .CE, .START, .OPMODE, .SLEEP, .BUSY, .OUT_VALID,
    .OUT_READY, .OUT_DATA, .MODE, .CS_N, .WR_N, .RD_N, .SLEEP_N, .VREF_ON, .INT_N, .RESULT_BUS);
  ahp_adc_model ahp_adc_model_i (.mode(MODE), .cs_n(CS_N), .wr_n(WR_N), .rd_n(RD_N),
    .sleep_n(SLEEP_N), .vin, .dly, .int_n(INT_N), .result_bus(RESULT_BUS));

  // ideal code of a level, msb on the top line
  function automatic logic [7:0] code(input logic [7:0] lvl);
    return lvl;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic hang;
    fails++;
    conclude;
  endtask

  // one conversion, slow or prompt converter
  task automatic conv(input logic [1:0] op, input logic [7:0] lvl);
    int n;
    OPMODE <= op;
    vin <= lvl;
    dly <= ($random(seed) & 1) ? 12'h04b0 : 12'h00c8;
    START <= 1'b1;
    for (n = 0; n < 9 && BUSY !== 1'b1; n++) @(posedge SYS_CLK);
    if (BUSY !== 1'b1) hang;
    START <= 1'b0;
    for (n = 0; n < 300 && BUSY !== 1'b0; n++) @(posedge SYS_CLK);
    if (BUSY !== 1'b0) hang;
  endtask

  // take results in order while stalling at random
  task automatic drain;
    int n;
    for (n = 0; n < 2000 && q.size() > 0; n++) begin
      @(posedge SYS_CLK);
      OUT_READY <= 1'($random(seed));
      @(negedge SYS_CLK);
      if ((OUT_VALID && OUT_READY) === 1'b1) check(OUT_DATA, q.pop_front());
    end
    if (q.size() > 0) hang;
    @(posedge SYS_CLK);
    OUT_READY <= 1'b0;
  endtask

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  // main sequence
  initial begin
    seed = 32'h573f;
    fails = 0;
    comparisons = 0;
    {RST, START, SLEEP, OUT_READY, OPMODE, vin, dly} = {1'b1, 13'h0000, 12'h00c8};
    CE = 1'b1;
    repeat (3) @(posedge SYS_CLK);
    check({CS_N, WR_N, RD_N, SLEEP_N, VREF_ON, MODE, BUSY, OUT_VALID}, 8'hfc);
    RST <= 1'b0;
    // fill with corner and random codes until the fifo refuses
    for (i = 0; i < 16; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      conv(2'($random(seed) & 1), v);
      q.push_back(code(v));
    end
    START <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    check({7'h0, BUSY}, 8'h00);
    START <= 1'b0;
    drain;
    // stand-alone hands over the previous byte; leaving drops it
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      conv(2'h2, v);
      if (i < 3) q.push_back(code(v));
    end
    // frozen enable keeps the stand-alone pins despite a new mode and start
    CE     <= 1'b0;
    OPMODE <= 2'h0;
    START  <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    check({5'h00, CS_N, RD_N, BUSY}, 8'h00);
    CE <= 1'b1;
    conv(2'h0, 8'h5a);
    q.push_back(code(8'h5a));
    drain;
    // sleep, wake, convert again
    SLEEP <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    check({5'h0, SLEEP_N, VREF_ON, BUSY}, 8'h01);
    SLEEP <= 1'b0;
    for (i = 0; i < 40 && BUSY !== 1'b0; i++) @(posedge SYS_CLK);
    if (BUSY !== 1'b0) hang;
    conv(2'h1, 8'ha5);
    q.push_back(code(8'ha5));
    drain;
    // nothing extra may be left behind in the fifo
    @(negedge SYS_CLK);
    check({7'h00, OUT_VALID}, 8'h00);
    conclude;
  end
endmodule

// ### ahp_pkg.sv
`include "ahp_consts.svh"

package ahp_pkg;

  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_WRLO  = 8'h02,
    ST_WINT  = 8'h04,
    ST_GAP   = 8'h08,
    ST_RDLO  = 8'h10,
    ST_ACQ   = 8'h20,
    ST_SLEEP = 8'h40,
    ST_WAKE  = 8'h80
  } ahp_state_t;

  // pins driven toward the converter
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic sleep_n;
    logic vref_on;
  } ahp_pins_t;

  // whole controller state
  typedef struct packed {
    ahp_state_t                 state;
    logic [`AHP_CNT_W-1:0]      cnt;
    logic [1:0]                 op;
    logic                       have_prev;
    logic                       push;
    logic [`AHP_DATA_W-1:0]     data;
    ahp_pins_t                  pins;
  } ahp_regs_t;

endpackage
